// ---- pin_mux_pkg.sv ----
/*
 Constants, register map and carrier types for the port A pin-function
 multiplexer. Assumes a 32-bit AXI4-Lite register bus and one 20 MHz clock.
*/
// Operation
// - Upper register bit 12 picks pin 22: I/O or upper-low byte write strobe.
// - Reserved control bits read back as 0; software writes 0 there.
// - Upper register bit 10 picks pin 21: I/O or high-high column strobe.
// - Upper register bit 8 picks pin 20: I/O or high-low column strobe.
// - Upper bits 7:6 pick pin 19: I/O, bus grant, DMA accept 1, reserved.
// - Upper bits 5:4 pick pin 18: I/O, bus request in, DMA accept 0, reserved.
// - Upper register bit 2 picks pin 17: I/O or wait request input.
// - Upper register bit 0 picks pin 16: I/O or address hold strobe.
// - Single chip mode keeps bus control and DMA accept pins as plain I/O.
// - ROM-invalid mode drives read, write strobes, chip selects 0/1 regardless.
// - Two lower control registers, 16 bits, read/write: pins 15-8 and 7-0.
// - Power-on: pins 15-8 register 4000 extended, 0000 single chip; 7-0 is 0000.
// - Manual, watchdog reset, standby, sleep leave lower control registers alone.
// - Pins 15-8 bit 14 picks pin 15: I/O or clock out; 1 after extended reset.
// - Pins 15-8 bit 12 picks pin 14: I/O or read strobe.
// - Pins 15-8 bit 10 picks pin 13: I/O or upper-half write strobe.
// - Pins 15-8 bit 8 picks pin 12: I/O or lower-half write strobe.
// - Pins 15-8 bit 6 picks pin 11: I/O or chip select 1.
// - Pins 15-8 bit 4 picks pin 10: I/O or chip select 0.
// - Pins 15-8 bits 3:2 pick pin 9: I/O, timer clock D, interrupt 3, reserved.
// - Pins 15-8 bits 1:0 pick pin 8: I/O, timer clock C, interrupt 2, reserved.
// - In I/O function the direction bit sets the pin: 1 output, 0 input.
// - Upper register loads 0000 at power-on and keeps contents otherwise.
package pin_mux_pkg;
    // Byte offsets on the register bus
    localparam logic [7:0] OFF_UPPER_CTRL = 8'h00;
    localparam logic [7:0] OFF_MID_CTRL = 8'h04;
    localparam logic [7:0] OFF_LOW_CTRL = 8'h08;
    localparam logic [7:0] OFF_UPPER_DIR = 8'h0c;
    localparam logic [7:0] OFF_LOWER_DIR = 8'h10;
    localparam logic [7:0] OFF_DATA_LATCH = 8'h14;
    localparam logic [7:0] OFF_PIN_LEVEL = 8'h18;
    localparam logic [7:0] OFF_MODE_STATUS = 8'h1c;

    // Writable-bit masks, reserved bits stay zero
    localparam logic [15:0] UPPER_CTRL_MASK = 16'h15f5;
    localparam logic [15:0] MID_CTRL_MASK = 16'h555f;
    localparam logic [15:0] LOW_CTRL_MASK = 16'hfd75;
    localparam logic [15:0] UPPER_DIR_MASK = 16'h00ff;
    localparam logic [22:0] DATA_LATCH_MASK = 23'h7fff00;

    // Power-on values
    localparam logic [15:0] UPPER_CTRL_RST = 16'h0000;
    localparam logic [15:0] MID_CTRL_RST_EXT = 16'h4000;
    localparam logic [15:0] MID_CTRL_RST_SC = 16'h0000;
    localparam logic [15:0] LOW_CTRL_RST = 16'h0000;

    // Field positions, upper register
    localparam int P22_BIT = 12;
    localparam int P21_BIT = 10;
    localparam int P20_BIT = 8;
    localparam int P19_LSB = 6;
    localparam int P18_LSB = 4;
    localparam int P17_BIT = 2;
    localparam int P16_BIT = 0;
    // Field positions, pins 15 to 8 register
    localparam int P15_BIT = 14;
    localparam int P14_BIT = 12;
    localparam int P13_BIT = 10;
    localparam int P12_BIT = 8;
    localparam int P11_BIT = 6;
    localparam int P10_BIT = 4;
    localparam int P9_LSB = 2;
    localparam int P8_LSB = 0;

    // Two-bit selector codes
    localparam logic [1:0] SEL_IO = 2'h0;
    localparam logic [1:0] SEL_FN_A = 2'h1;
    localparam logic [1:0] SEL_FN_B = 2'h2;

    // Strap settling cycles before the power-on load
    localparam logic [1:0] STRAP_SETTLE = 2'h3;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Outgoing function levels from the bus and DMA controllers
    typedef struct packed {
        logic upper_low_byte_write_strobe;
        logic column_strobe_high_high;
        logic column_strobe_high_low;
        logic bus_grant_ack;
        logic dma_request_accepted_1;
        logic dma_request_accepted_0;
        logic address_hold_strobe;
        logic system_clock;
        logic read_strobe;
        logic upper_half_write_strobe;
        logic lower_half_write_strobe;
        logic chip_select_1;
        logic chip_select_0;
    } fn_out_s;

    // Incoming function levels handed to peripherals
    typedef struct packed {
        logic bus_request_in;
        logic wait_request;
        logic timer_ext_clock_d;
        logic timer_ext_clock_c;
        logic external_interrupt_3;
        logic external_interrupt_2;
    } fn_in_s;

    // Idle levels when a peripheral input is not routed (bus inputs active low)
    localparam fn_in_s FN_IN_IDLE = 6'b110000;

    typedef enum logic [2:0] {
        ST_SETTLE = 3'b001,
        ST_LOAD = 3'b010,
        ST_RUN = 3'b100
    } init_state_e;
endpackage

// ---- port_a_pin_function_select.sv ----
/*
 Port A pin-function multiplexer for pins 8 to 22 with its control,
 direction and data registers on an AXI4-Lite slave. Assumes rst_n is the
 external power-on reset; other reset sources never reach this block, and
 mode straps and pins are asynchronous and synchronised here.
*/
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module port_a_pin_function_select
    import pin_mux_pkg::*;
#(
    parameter int PIN_LO = 8,
    parameter int PIN_HI = 22
) (
    // Clock and power-on reset
    input wire logic clk,
    input wire logic rst_n,
    // Mode straps
    input wire logic mode_single_chip,
    input wire logic mode_rom_invalid,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Peripheral side
    input wire fn_out_s fn_out,
    output fn_in_s fn_in,
    // Pins
    input wire logic [PIN_HI:PIN_LO] pin_in,
    output logic [PIN_HI:PIN_LO] pin_out,
    output logic [PIN_HI:PIN_LO] pin_oe
);

    logic [15:0] upper_ctrl_r;
    logic [15:0] mid_ctrl_r;
    logic [15:0] low_ctrl_r;
    logic [15:0] upper_dir_r;
    logic [15:0] lower_dir_r;
    logic [22:0] data_latch_r;
    logic [PIN_HI:PIN_LO] pin_meta_r;
    logic [PIN_HI:PIN_LO] pin_sync_r;
    logic [1:0] mode_meta_r;
    logic [1:0] mode_sync_r;
    logic [1:0] settle_r;
    init_state_e init_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic aw_held;
    logic w_held;
    logic do_write;
    logic [31:0] rd_word;
    logic rd_hit;
    logic single_chip;
    logic rom_invalid;
    logic [PIN_HI:PIN_LO] drive_fn;
    logic [PIN_HI:PIN_LO] take_fn;
    logic [PIN_HI:PIN_LO] drive_val;
    logic [PIN_HI:PIN_LO] io_dir;
    logic [1:0] sel19;
    logic [1:0] sel18;
    logic [1:0] sel9;
    logic [1:0] sel8;

    // Merge a bus write into a register under byte strobes and a write mask
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be, input logic [31:0] mask);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return res & mask;
    endfunction

    // Two-flop synchronisers for pins and straps
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_r <= '0;
            pin_sync_r <= '0;
            mode_meta_r <= '0;
            mode_sync_r <= '0;
        end else begin
            pin_meta_r <= pin_in;
            pin_sync_r <= pin_meta_r;
            mode_meta_r <= {mode_rom_invalid, mode_single_chip};
            mode_sync_r <= mode_meta_r;
        end
    end

    assign single_chip = mode_sync_r[0];
    assign rom_invalid = mode_sync_r[1];

    // Strap capture: wait for the synchronisers to fill, then load once
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            init_r <= ST_SETTLE;
            settle_r <= '0;
        end else begin
            case (init_r)
                ST_SETTLE: begin
                    settle_r <= settle_r + 2'h1;
                    if (settle_r == STRAP_SETTLE - 2'h1) begin
                        init_r <= ST_LOAD;
                    end
                end
                ST_LOAD: init_r <= ST_RUN;
                ST_RUN: init_r <= ST_RUN;
                default: init_r <= ST_SETTLE;
            endcase
        end
    end

    assign aw_held = !s_axi_awready && (init_r == ST_RUN);
    assign w_held = !s_axi_wready && (init_r == ST_RUN);
    assign do_write = aw_held && w_held && !s_axi_bvalid;

    // Write channels: address and data taken in either order, then one response
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
        end else if (init_r == ST_LOAD) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_r <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awaddr_r[7:2] <= OFF_LOWER_DIR[7:2] + 6'h1) ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Control registers; only power-on reset clears them, nothing else does
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            upper_ctrl_r <= UPPER_CTRL_RST;
            mid_ctrl_r <= MID_CTRL_RST_SC;
            low_ctrl_r <= LOW_CTRL_RST;
        end else if (init_r == ST_LOAD) begin
            mid_ctrl_r <= single_chip ? MID_CTRL_RST_SC : MID_CTRL_RST_EXT;
        end else if (do_write) begin
            // Masks keep reserved bits at zero whatever is written
            case (awaddr_r)
                OFF_UPPER_CTRL: upper_ctrl_r <= 16'(merge({16'h0, upper_ctrl_r}, wdata_r, wstrb_r,
                                                     {16'h0, UPPER_CTRL_MASK}));
                OFF_MID_CTRL: mid_ctrl_r <= 16'(merge({16'h0, mid_ctrl_r}, wdata_r, wstrb_r,
                                                 {16'h0, MID_CTRL_MASK}));
                OFF_LOW_CTRL: low_ctrl_r <= 16'(merge({16'h0, low_ctrl_r}, wdata_r, wstrb_r,
                                                 {16'h0, LOW_CTRL_MASK}));
                default: ;
            endcase
        end
    end
    // Standby, sleep and the soft resets have no path into the block at all.

    // Direction and data latch registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            upper_dir_r <= '0;
            lower_dir_r <= '0;
            data_latch_r <= '0;
        end else if (do_write) begin
            case (awaddr_r)
                OFF_UPPER_DIR: upper_dir_r <= 16'(merge({16'h0, upper_dir_r}, wdata_r, wstrb_r,
                                                   {16'h0, UPPER_DIR_MASK}));
                OFF_LOWER_DIR: lower_dir_r <= 16'(merge({16'h0, lower_dir_r}, wdata_r, wstrb_r,
                                                   32'h0000ffff));
                OFF_DATA_LATCH: data_latch_r <= 23'(merge({9'h0, data_latch_r}, wdata_r, wstrb_r,
                                                     {9'h0, DATA_LATCH_MASK}));
                default: ;
            endcase
        end
    end

    // Read decode
    always_comb begin
        rd_word = '0;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            OFF_UPPER_CTRL: rd_word = {16'h0, upper_ctrl_r};
            OFF_MID_CTRL: rd_word = {16'h0, mid_ctrl_r};
            OFF_LOW_CTRL: rd_word = {16'h0, low_ctrl_r};
            OFF_UPPER_DIR: rd_word = {16'h0, upper_dir_r};
            OFF_LOWER_DIR: rd_word = {16'h0, lower_dir_r};
            OFF_DATA_LATCH: rd_word = {9'h0, data_latch_r};
            OFF_PIN_LEVEL: rd_word = {9'h0, pin_sync_r, 8'h0};
            OFF_MODE_STATUS: rd_word = {29'h0, !single_chip, rom_invalid, single_chip};
            default: rd_hit = 1'b0;
        endcase
    end

    // Read channel: one read in flight, answered the cycle after it is taken
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (init_r == ST_LOAD) begin
            s_axi_arready <= 1'b1;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    assign sel19 = upper_ctrl_r[P19_LSB +: 2];
    assign sel18 = upper_ctrl_r[P18_LSB +: 2];
    assign sel9 = mid_ctrl_r[P9_LSB +: 2];
    assign sel8 = mid_ctrl_r[P8_LSB +: 2];

    // Effective function per pin after mode overrides
    always_comb begin
        drive_fn = '0;
        take_fn = '0;
        drive_val = '0;
        // Bus strobes are withheld in single chip mode; read, write strobes and chip selects are forced when ROM is invalid
        if ((upper_ctrl_r[P22_BIT] && !single_chip) || rom_invalid) begin
            drive_fn[22] = 1'b1;
            drive_val[22] = fn_out.upper_low_byte_write_strobe;
        end
        if (upper_ctrl_r[P21_BIT] && !single_chip) begin
            drive_fn[21] = 1'b1;
            drive_val[21] = fn_out.column_strobe_high_high;
        end
        if (upper_ctrl_r[P20_BIT] && !single_chip) begin
            drive_fn[20] = 1'b1;
            drive_val[20] = fn_out.column_strobe_high_low;
        end
        if (!single_chip) begin
            case (sel19)
                SEL_FN_A: begin
                    drive_fn[19] = 1'b1;
                    drive_val[19] = fn_out.bus_grant_ack;
                end
                SEL_FN_B: begin
                    drive_fn[19] = 1'b1;
                    drive_val[19] = fn_out.dma_request_accepted_1;
                end
                default: ;
            endcase
            case (sel18)
                SEL_FN_A: take_fn[18] = 1'b1;
                SEL_FN_B: begin
                    drive_fn[18] = 1'b1;
                    drive_val[18] = fn_out.dma_request_accepted_0;
                end
                default: ;
            endcase
            take_fn[17] = upper_ctrl_r[P17_BIT];
            if (upper_ctrl_r[P16_BIT]) begin
                drive_fn[16] = 1'b1;
                drive_val[16] = fn_out.address_hold_strobe;
            end
        end
        if (mid_ctrl_r[P15_BIT]) begin
            drive_fn[15] = 1'b1;
            drive_val[15] = fn_out.system_clock;
        end
        if ((mid_ctrl_r[P14_BIT] && !single_chip) || rom_invalid) begin
            drive_fn[14] = 1'b1;
            drive_val[14] = fn_out.read_strobe;
        end
        if ((mid_ctrl_r[P13_BIT] && !single_chip) || rom_invalid) begin
            drive_fn[13] = 1'b1;
            drive_val[13] = fn_out.upper_half_write_strobe;
        end
        if ((mid_ctrl_r[P12_BIT] && !single_chip) || rom_invalid) begin
            drive_fn[12] = 1'b1;
            drive_val[12] = fn_out.lower_half_write_strobe;
        end
        if ((mid_ctrl_r[P11_BIT] && !single_chip) || rom_invalid) begin
            drive_fn[11] = 1'b1;
            drive_val[11] = fn_out.chip_select_1;
        end
        if ((mid_ctrl_r[P10_BIT] && !single_chip) || rom_invalid) begin
            drive_fn[10] = 1'b1;
            drive_val[10] = fn_out.chip_select_0;
        end
        // Reserved code 11 falls through to plain I/O
        take_fn[9] = (sel9 == SEL_FN_A) || (sel9 == SEL_FN_B);
        take_fn[8] = (sel8 == SEL_FN_A) || (sel8 == SEL_FN_B);
    end

    assign io_dir = {upper_dir_r[6:0], lower_dir_r[15:8]};

    // Pin drivers; peripheral inputs never enable the pad driver
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_out <= '0;
            pin_oe <= '0;
        end else begin
            pin_oe <= drive_fn | (~drive_fn & ~take_fn & io_dir);
            pin_out <= (drive_fn & drive_val) | (~drive_fn & data_latch_r[PIN_HI:PIN_LO]);
        end
    end

    // Peripheral inputs, idle level when not routed
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fn_in <= FN_IN_IDLE;
        end else begin
            fn_in.bus_request_in <= take_fn[18] ? pin_sync_r[18] : FN_IN_IDLE.bus_request_in;
            fn_in.wait_request <= take_fn[17] ? pin_sync_r[17] : FN_IN_IDLE.wait_request;
            fn_in.timer_ext_clock_d <= (sel9 == SEL_FN_A) && pin_sync_r[9];
            fn_in.external_interrupt_3 <= (sel9 == SEL_FN_B) && pin_sync_r[9];
            fn_in.timer_ext_clock_c <= (sel8 == SEL_FN_A) && pin_sync_r[8];
            fn_in.external_interrupt_2 <= (sel8 == SEL_FN_B) && pin_sync_r[8];
        end
    end

endmodule // port_a_pin_function_select

// ---- pin_mux_checker.sv ----
/*
 Concurrent checks on the top ports of the port A pin multiplexer.
 Assumes one clock and the async power-on reset; bound at the foot.
*/
`timescale 1ns/10ps
module pin_mux_checker
    import pin_mux_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Strap and bus handshakes
    input wire logic mode_rom_invalid,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    // Pin side
    input wire fn_out_s fn_out,
    input wire logic [22:8] pin_out,
    input wire logic [22:8] pin_oe
);
    // Pins forced to bus strobes while on-chip ROM is off
    localparam logic [22:8] ROM_PINS = 15'h407c;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    reset_quiet_a: assert property ($rose(rst_n) |-> pin_oe == 15'h0000 && !s_axi_awready && !s_axi_arready)
        else $error("outputs active right after reset");
    bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped before taken");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed before taken");
    rdata_upper_a: assert property (s_axi_rvalid && s_axi_rresp == RESP_OKAY |-> s_axi_rdata[31:23] == 9'h000)
        else $error("unused read bits not zero");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
    write_single_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("second write taken during response");
    rom_oe_a: assert property (mode_rom_invalid [*8] |-> (pin_oe & ROM_PINS) == ROM_PINS)
        else $error("strobe pins not driven with ROM off");
    rom_data_a: assert property (mode_rom_invalid [*8] |-> pin_out[14] == $past(fn_out.read_strobe)
        && pin_out[10] == $past(fn_out.chip_select_0)) else $error("strobe level not passed to pin");

    // Main scenarios reached
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == RESP_SLVERR);
    cover property (mode_rom_invalid [*8]);
endmodule // pin_mux_checker

bind port_a_pin_function_select pin_mux_checker u_pin_mux_checker (
    .clk, .rst_n, .mode_rom_invalid, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .fn_out, .pin_out, .pin_oe
);

// ---- port_a_pin_function_select_tb.sv ----
/*
 Self-checking bench for the port A pin-function multiplexer.
 Drives the AXI4-Lite slave, straps and pins directly at a 20 MHz clock.
*/
`timescale 1ns/10ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; $display("mismatch %s exp %h got %h", n, e, g); end end
module port_a_pin_function_select_tb import pin_mux_pkg::*;;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic mode_single_chip = 1'b0;
    logic mode_rom_invalid = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    fn_out_s fn_out = 13'h0000;
    fn_in_s fn_in;
    logic [22:8] pin_in = 15'h0000, pin_out, pin_oe;
    int bad_count = 0, tests_run = 0;

    // 20 MHz clock
    initial begin
        forever #25 clk = ~clk;
    end

    port_a_pin_function_select u_port_a_pin_function_select (
        .clk, .rst_n, .mode_single_chip, .mode_rom_invalid, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .fn_out, .fn_in, .pin_in, .pin_out, .pin_oe
    );

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Power-on reset with the single chip strap set beforehand
    task automatic por(input logic sc);
        rst_n <= 1'b0;
        mode_single_chip <= sc;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
    endtask

    // Ready is taken late on purpose so the slave must hold its answer
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge clk);
            s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
            s_axi_wvalid <= s_axi_wvalid && !s_axi_wready;
        end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
        do @(posedge clk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b1;
        @(posedge clk);
        s_axi_bready <= 1'b0;
        `CHK("bresp", er, s_axi_bresp)
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b1;
        @(posedge clk);
        s_axi_rready <= 1'b0;
        `CHK("rdata", ed, s_axi_rdata)
        `CHK("rresp", er, s_axi_rresp)
    endtask

    // Long settle covers strap synchronisers plus the output register
    task automatic pins(input logic [22:8] eoe, input logic [22:8] eout, input fn_in_s ein);
        repeat (8) @(posedge clk);
        `CHK("pin_oe", eoe, pin_oe)
        `CHK("pin_out", eout & eoe, pin_out & eoe)
        `CHK("fn_in", ein, fn_in)
    endtask

    task automatic reg_check();
        logic [15:0] msk [3] = '{16'h15f5, 16'h555f, 16'hfd75};
        rd(OFF_MODE_STATUS, 32'h4, RESP_OKAY);
        rd(OFF_UPPER_CTRL, 32'h0, RESP_OKAY);
        rd(OFF_MID_CTRL, 32'h4000, RESP_OKAY);
        rd(OFF_LOW_CTRL, 32'h0, RESP_OKAY);
        for (int i = 0; i < 3; i++) begin
            wr(8'(4 * i), 32'hffffffff, RESP_OKAY);
            rd(8'(4 * i), {16'h0000, msk[i]}, RESP_OKAY);
        end
        wr(8'h20, 32'h1, RESP_SLVERR);
        rd(8'h20, 32'h0, RESP_SLVERR);
    endtask

    // Each field value: offset, value, output pin, output bit, input pin, input bit
    task automatic mux_table(input logic sc);
        int t [23][6] = '{'{0, 16'h1000, 22, 12, 0, 0}, '{0, 16'h0400, 21, 11, 0, 0}, '{0, 16'h0100, 20, 10, 0, 0},
            '{0, 16'h0040, 19, 9, 0, 0}, '{0, 16'h0080, 19, 8, 0, 0}, '{0, 16'h0020, 18, 7, 0, 0},
            '{0, 16'h0001, 16, 6, 0, 0}, '{0, 16'h0010, 0, 0, 18, 5}, '{0, 16'h0004, 0, 0, 17, 4},
            '{0, 16'h00c0, 0, 0, 0, 0}, '{0, 16'h0030, 0, 0, 0, 0}, '{4, 16'h4000, 15, 5, 0, 0},
            '{4, 16'h1000, 14, 4, 0, 0}, '{4, 16'h0400, 13, 3, 0, 0}, '{4, 16'h0100, 12, 2, 0, 0},
            '{4, 16'h0040, 11, 1, 0, 0}, '{4, 16'h0010, 10, 0, 0, 0}, '{4, 16'h0004, 0, 0, 9, 3},
            '{4, 16'h0008, 0, 0, 9, 1}, '{4, 16'h0001, 0, 0, 8, 2}, '{4, 16'h0002, 0, 0, 8, 0},
            '{4, 16'h000c, 0, 0, 0, 0}, '{4, 16'h0003, 0, 0, 0, 0}};
        logic [22:0] fm, im;
        fn_in_s ib;
        logic sup;
        wr(OFF_UPPER_CTRL, 32'h0, RESP_OKAY);
        wr(OFF_MID_CTRL, 32'h0, RESP_OKAY);
        wr(OFF_DATA_LATCH, 32'h7fff00, RESP_OKAY);
        pins(15'h0000, 15'h0000, FN_IN_IDLE);
        wr(OFF_UPPER_DIR, 32'h7f, RESP_OKAY);
        wr(OFF_LOWER_DIR, 32'hff00, RESP_OKAY);
        pins(15'h7fff, 15'h7fff, FN_IN_IDLE);
        for (int i = 0; i < 23; i++) begin
            sup = sc && ((t[i][2] + t[i][4]) inside {[10:14], [16:22]});
            fm = (t[i][2] != 0 && !sup) ? 23'h1 << t[i][2] : 23'h0;
            im = (t[i][4] != 0 && !sup) ? 23'h1 << t[i][4] : 23'h0;
            ib = (im != 0) ? fn_in_s'(6'h1 << t[i][5]) : fn_in_s'(6'h0);
            wr(8'(t[i][0]), 32'(t[i][1]), RESP_OKAY);
            fn_out <= fn_out_s'(13'h1 << t[i][3]);
            pin_in <= im[22:8];
            pins(~im[22:8], 15'h7fff, FN_IN_IDLE | ib);
            fn_out <= fn_out_s'(~(13'h1 << t[i][3]));
            pin_in <= ~im[22:8];
            pins(~im[22:8], ~fm[22:8], FN_IN_IDLE & ~ib);
            wr(8'(t[i][0]), 32'h0, RESP_OKAY);
        end
        rd(OFF_PIN_LEVEL, 32'h7fff00, RESP_OKAY);
        wr(OFF_UPPER_DIR, 32'h0, RESP_OKAY);
        wr(OFF_LOWER_DIR, 32'h0, RESP_OKAY);
        mode_rom_invalid <= 1'b1;
        fn_out <= fn_out_s'(13'h1fee);
        pins(15'h407c, 15'h4038, FN_IN_IDLE);
        mode_rom_invalid <= 1'b0;
    endtask

    // Main sequence: extended mode, then single chip mode
    initial begin
        por(1'b0);
        reg_check();
        mux_table(1'b0);
        wr(OFF_UPPER_CTRL, 32'h15f5, RESP_OKAY);
        por(1'b1);
        rd(OFF_MID_CTRL, 32'h0, RESP_OKAY);
        rd(OFF_MODE_STATUS, 32'h1, RESP_OKAY);
        rd(OFF_UPPER_CTRL, 32'h0, RESP_OKAY);
        mux_table(1'b1);
        wrap_up();
    end

    // Hang guard, far beyond the expected 1400 or so cycles
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        wrap_up();
    end
endmodule // port_a_pin_function_select_tb
